// *** pkg/epi_pkg.sv ***
// Package: map, fields, states and types of the external bus pin interface
package epi_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W  = 32; // Data bus pins
  localparam int PADDR_W = 27; // Location bus pins
  localparam int XADDR_W = 30; // Full external space
  localparam int AXI_AW  = 8;  // Register byte address
  localparam int BANK_LSB = 27; // Bank index bits
  localparam int REG_LSB  = 20; // 1 MB region grain

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_ADDR  = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_BANK  = 8'h20; // Eight words
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_ERR  = 2;
  localparam int SB_HOLD = 3;
  localparam int SB_BOOT = 4; // Two bits
  localparam int SB_TEST = 6;
  localparam int BK_CYC_LSB  = 0;
  localparam int BK_WID_LSB  = 4;
  localparam int BK_SIZE_LSB = 8;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] W8  = 2'b00;
  localparam logic [1:0] W16 = 2'b01;
  localparam logic [1:0] W32 = 2'b10;
  localparam logic [1:0] BOOT_16   = 2'b01;
  localparam logic [1:0] BOOT_32   = 2'b10;
  localparam logic [1:0] BOOT_TEST = 2'b11;
  localparam logic [31:0] MASK_8  = 32'h0000_00FF;
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFF_FFFF;
  localparam logic [3:0] CYC_RST    = 4'h7;
  localparam logic [3:0] CYC_MIN    = 4'h1;
  localparam logic [3:0] CYC_MAX    = 4'hF;
  localparam logic [2:0] SIZE_RST   = 3'h7;
  localparam logic [6:0] REGION_ALL = 7'h7F;
  localparam logic [7:0] SEL_IDLE   = 8'hFF;
  localparam logic [7:0] SEL_ONE    = 8'h01;
  localparam logic [1:0] STRAP_LAST = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  // Sync vector: boot[35:34], hold req[33], extend[32], data
  localparam logic [35:0] SYNC_RST = 36'h3_0000_0000;

  typedef struct packed {
    logic [2:0] size;   // Region is 1 MB << size
    logic [1:0] width;  // Bus width code
    logic [3:0] cycles; // Strobe length control
  } epi_bank_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_FINISH = 3'b010,
    ST_GRANT  = 3'b110
  } epi_state_e;
endpackage

// *** rtl/epi_top.sv ***
// External bus pin interface with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module epi_top (
  input  wire logic                       SYS_CLK_I,   // 125 MHz
  input  wire logic                       RST_I,       // Async, high
  input  wire logic [epi_pkg::AXI_AW-1:0] S_AWADDR_I,  // Write address
  input  wire logic                       S_AWVALID_I, // Write addr valid
  output var  logic                       S_AWREADY_O, // Write addr ready
  input  wire logic [epi_pkg::DATA_W-1:0] S_WDATA_I,   // Write data
  input  wire logic [3:0]                 S_WSTRB_I,   // Byte strobes
  input  wire logic                       S_WVALID_I,  // Write data valid
  output var  logic                       S_WREADY_O,  // Write data ready
  output var  logic [1:0]                 S_BRESP_O,   // Write response
  output var  logic                       S_BVALID_O,  // Response valid
  input  wire logic                       S_BREADY_I,  // Response ready
  input  wire logic [epi_pkg::AXI_AW-1:0] S_ARADDR_I,  // Read address
  input  wire logic                       S_ARVALID_I, // Read addr valid
  output var  logic                       S_ARREADY_O, // Read addr ready
  output var  logic [epi_pkg::DATA_W-1:0] S_RDATA_O,   // Read data
  output var  logic [1:0]                 S_RRESP_O,   // Read response
  output var  logic                       S_RVALID_O,  // Read valid
  input  wire logic                       S_RREADY_I,  // Read ready
  input  wire logic [1:0]                 BOOT_CONFIG_PINS_I,    // Straps
  output var  logic [epi_pkg::PADDR_W-1:0] ADDR_O,            // Location
  output var  logic                       BUS_OE_O,          // Pad enable
  input  wire logic [epi_pkg::DATA_W-1:0] DATA_I,            // Data in
  output var  logic [epi_pkg::DATA_W-1:0] DATA_O,            // Data out
  output var  logic                       DATA_OE_O,         // Data enable
  output var  logic [7:0]                 BANK_SELECT_N_O,   // Selects
  output var  logic                       WRITE_STROBE_N_O,  // Write
  output var  logic                       READ_STROBE_N_O,   // Read
  input  wire logic                       BUS_HOLD_REQUEST_N_I, // Request
  output var  logic                       BUS_HOLD_GRANT_N_O,   // Grant
  input  wire logic                       CYCLE_EXTEND_N_I      // Extend
);
  import epi_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [35:0] sync1_reg, sync2_reg;
  logic [1:0]  boot_s2;
  logic        req_s2, wait_s2;
  logic [31:0] din_s2;
  logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wbuf_reg, wbuf_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic        arready_reg, arready_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rbus_reg, rbus_next;
  logic        go_reg, go_next, dir_reg, dir_next;
  logic        done_reg, done_next, err_reg, err_next;
  logic [29:0] xaddr_reg, xaddr_next;
  logic [31:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic [1:0]  boot_reg, boot_next, strap_reg, strap_next, boot_w;
  epi_bank_s   bank_reg [8];
  epi_bank_s   bank_next [8];
  epi_state_e  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next, lim;
  logic [26:0] pa_reg, pa_next;
  logic [7:0]  sel_reg, sel_next;
  logic [2:0]  cur_reg, cur_next, bank;
  logic        we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic [31:0] dout_reg, dout_next;
  logic        doe_reg, doe_next, boe_reg, boe_next;
  logic        gnt_n_reg, gnt_n_next;
  logic        fsm_take, fsm_done, fsm_err, busy, hit, strap_take;
  logic [31:0] wv;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Every pin input crosses two flops before any logic looks at it
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {BOOT_CONFIG_PINS_I, BUS_HOLD_REQUEST_N_I,
                    CYCLE_EXTEND_N_I, DATA_I};
      sync2_reg <= sync1_reg;
    end
  end
  assign {boot_s2, req_s2, wait_s2, din_s2} = sync2_reg;

  // Shared decode terms
  assign busy = (state_reg != ST_IDLE) || go_reg;
  assign bank = xaddr_reg[BANK_LSB+:3];
  assign hit = (xaddr_reg[BANK_LSB-1:REG_LSB] &
                7'(REGION_ALL << bank_reg[bank].size)) == 7'h00;
  assign lim = (bank_reg[cur_reg].cycles < CYC_MIN) ? CYC_MIN
             : bank_reg[cur_reg].cycles;
  assign strap_take = (strap_reg == STRAP_LAST);

  function automatic logic [31:0] lane_mask(input logic [1:0] w);
    lane_mask = (w == W8) ? MASK_8 : (w == W16) ? MASK_16 : MASK_32;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) &&
             ((a <= OFS_STAT) || (a[7:5] == OFS_BANK[7:5]));
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      OFS_CTRL: begin
        w[CTRL_GO] = go_reg;
        w[CTRL_WR] = dir_reg;
      end
      OFS_ADDR:  w[XADDR_W-1:0] = xaddr_reg;
      OFS_WDATA: w = wdat_reg;
      OFS_RDATA: w = rdat_reg;
      OFS_STAT: begin
        w[SB_BUSY] = busy;
        w[SB_DONE] = done_reg;
        w[SB_ERR] = err_reg;
        w[SB_HOLD] = ~gnt_n_reg;
        w[SB_BOOT+:2] = boot_reg;
        w[SB_TEST] = (boot_reg == BOOT_TEST);
      end
      default: begin
        if (a[7:5] == OFS_BANK[7:5]) begin
          w[BK_CYC_LSB+:4] = bank_reg[a[4:2]].cycles;
          w[BK_WID_LSB+:2] = bank_reg[a[4:2]].width;
          w[BK_SIZE_LSB+:3] = bank_reg[a[4:2]].size;
        end
      end
    endcase
    rd_word = w;
  endfunction

  // Strap code to bank-0 width; nand boot runs the bank at 8 bits
  always_comb begin
    case (boot_s2)
      BOOT_16: boot_w = W16;
      BOOT_32, BOOT_TEST: boot_w = W32;
      default: boot_w = W8;
    endcase
  end

  // ****************************************
  // AXI4-Lite slave and registers
  // ****************************************
  // Address and data are taken in either order; one write in flight
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wbuf_next = wbuf_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rbus_next = rbus_reg;
    go_next = go_reg & ~fsm_take;
    dir_next = dir_reg;
    done_next = done_reg;
    err_next = err_reg;
    xaddr_next = xaddr_reg;
    wdat_next = wdat_reg;
    boot_next = boot_reg;
    strap_next = strap_reg;
    bank_next = bank_reg;
    wv = rd_word(awaddr_reg);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_reg[i]) wv[8*i+:8] = wbuf_reg[8*i+:8];
    end
    if (S_AWVALID_I && awready_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = S_AWADDR_I;
    end
    if (S_WVALID_I && wready_reg) begin
      w_hold_next = 1'b1;
      wbuf_next = S_WDATA_I;
      wstrb_next = S_WSTRB_I;
    end
    if (bvalid_reg && S_BREADY_I) bvalid_next = 1'b0;
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? RESP_OK : RESP_SLVERR;
      case (awaddr_reg)
        // A start while busy is dropped so a running cycle stays intact
        OFS_CTRL: begin
          if (!busy) begin
            go_next = wv[CTRL_GO];
            dir_next = wv[CTRL_WR];
          end
        end
        OFS_ADDR:  xaddr_next = wv[XADDR_W-1:0];
        OFS_WDATA: wdat_next = wv;
        OFS_STAT: begin
          done_next = done_reg & ~wv[SB_DONE];
          err_next = err_reg & ~wv[SB_ERR];
        end
        default: begin
          if (mapped(awaddr_reg) && awaddr_reg[7:5] == OFS_BANK[7:5]) begin
            bank_next[awaddr_reg[4:2]].cycles = wv[BK_CYC_LSB+:4];
            bank_next[awaddr_reg[4:2]].width = wv[BK_WID_LSB+:2];
            bank_next[awaddr_reg[4:2]].size = wv[BK_SIZE_LSB+:3];
          end
        end
      endcase
    end
    // Hardware set beats a software clear in the same cycle
    if (fsm_done) done_next = 1'b1;
    if (fsm_err) err_next = 1'b1;
    if (rvalid_reg && S_RREADY_I) rvalid_next = 1'b0;
    if (S_ARVALID_I && arready_reg) begin
      rvalid_next = 1'b1;
      rbus_next = rd_word(S_ARADDR_I);
      rresp_next = mapped(S_ARADDR_I) ? RESP_OK : RESP_SLVERR;
    end
    // Straps are caught once the synchroniser holds them after release
    if (strap_reg != STRAP_DONE) strap_next = strap_reg + 2'h1;
    if (strap_take) begin
      boot_next = boot_s2;
      bank_next[0].width = boot_w;
    end
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      {aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg} <= 4'h0;
      {awready_reg, wready_reg, arready_reg} <= 3'h0;
      {go_reg, dir_reg, done_reg, err_reg} <= 4'h0;
      awaddr_reg <= 8'h00;
      wbuf_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= RESP_OK;
      rresp_reg <= RESP_OK;
      rbus_reg <= 32'h0000_0000;
      xaddr_reg <= 30'h0000_0000;
      wdat_reg <= 32'h0000_0000;
      boot_reg <= 2'h0;
      strap_reg <= 2'h0;
      for (int i = 0; i < 8; i++) begin
        bank_reg[i] <= '{size: SIZE_RST, width: W32, cycles: CYC_RST};
      end
    end else begin
      {aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg} <=
        {aw_hold_next, w_hold_next, bvalid_next, rvalid_next};
      {awready_reg, wready_reg, arready_reg} <=
        {awready_next, wready_next, arready_next};
      {go_reg, dir_reg, done_reg, err_reg} <=
        {go_next, dir_next, done_next, err_next};
      awaddr_reg <= awaddr_next;
      wbuf_reg <= wbuf_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rbus_reg <= rbus_next;
      xaddr_reg <= xaddr_next;
      wdat_reg <= wdat_next;
      boot_reg <= boot_next;
      strap_reg <= strap_next;
      bank_reg <= bank_next;
    end
  end

  // ****************************************
  // External bus sequencer
  // ****************************************
  // Hold requests are served only between cycles, never mid-cycle
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pa_next = pa_reg;
    sel_next = sel_reg;
    cur_next = cur_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    boe_next = boe_reg;
    gnt_n_next = gnt_n_reg;
    rdat_next = rdat_reg;
    fsm_take = 1'b0;
    fsm_done = 1'b0;
    fsm_err = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (!req_s2) begin
          state_next = ST_GRANT;
          boe_next = 1'b0;
        end else if (go_reg) begin
          fsm_take = 1'b1;
          if (!hit) begin
            fsm_err = 1'b1;
            fsm_done = 1'b1;
          end else begin
            state_next = ST_SETUP;
            pa_next = xaddr_reg[PADDR_W-1:0];
            sel_next = ~(SEL_ONE << bank);
            cur_next = bank;
            cnt_next = 4'h0;
            doe_next = dir_reg;
            dout_next = wdat_reg & lane_mask(bank_reg[bank].width);
          end
        end
      end
      ST_SETUP: begin
        state_next = ST_STROBE;
        we_n_next = ~dir_reg;
        oe_n_next = dir_reg;
      end
      ST_STROBE: begin
        if (cnt_reg != CYC_MAX) cnt_next = cnt_reg + 4'h1;
        if (cnt_reg >= lim && wait_s2) begin
          state_next = ST_FINISH;
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
        sel_next = SEL_IDLE;
        doe_next = 1'b0;
        fsm_done = 1'b1;
        // Sample lags the pin by two flops, still inside the strobe
        if (!dir_reg) rdat_next = din_s2 & lane_mask(bank_reg[cur_reg].width);
      end
      ST_GRANT: begin
        if (!req_s2) begin
          gnt_n_next = 1'b0;
        end else begin
          gnt_n_next = 1'b1;
          if (gnt_n_reg) begin
            state_next = ST_IDLE;
            boe_next = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      pa_reg <= 27'h000_0000;
      sel_reg <= SEL_IDLE;
      cur_reg <= 3'h0;
      {we_n_reg, oe_n_reg, gnt_n_reg, boe_reg, doe_reg} <= 5'b11110;
      dout_reg <= 32'h0000_0000;
      rdat_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pa_reg <= pa_next;
      sel_reg <= sel_next;
      cur_reg <= cur_next;
      {we_n_reg, oe_n_reg, gnt_n_reg, boe_reg, doe_reg} <=
        {we_n_next, oe_n_next, gnt_n_next, boe_next, doe_next};
      dout_reg <= dout_next;
      rdat_reg <= rdat_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  grant_release_a: assert property (!gnt_n_reg |-> !boe_reg && !doe_reg)
    else $error("Grant while pins still driven");
  grant_cause_a: assert property ($fell(gnt_n_reg) |-> $past(!req_s2) && $past(!boe_reg))
    else $error("Grant without request or before release");
  hold_enter_a: assert property (state_reg == ST_IDLE && !req_s2 |=> !boe_reg ##1 1)
    else $error("Hold request not honoured");
  extend_stall_a: assert property (state_reg == ST_STROBE && !wait_s2 |=> state_reg == ST_STROBE)
    else $error("Cycle ended while extend low");
  one_select_a: assert property ($onehot0(~sel_reg) && ((we_n_reg && oe_n_reg) || sel_reg != SEL_IDLE))
    else $error("Bad bank select");
  write_strobe_a: assert property (!we_n_reg |-> dir_reg && doe_reg && oe_n_reg)
    else $error("Write strobe outside a write");
  read_strobe_a: assert property (!oe_n_reg |-> !dir_reg && !doe_reg)
    else $error("Read strobe outside a read");
  strobe_len_a: assert property (state_reg == ST_SETUP |=> (!we_n_reg || !oe_n_reg) [*2])
    else $error("Strobe shorter than two cycles");
  addr_stable_a: assert property (state_reg == ST_STROBE |-> $stable(pa_reg) && $stable(sel_reg))
    else $error("Location moved during strobe");
  strap_width_a: assert property (strap_take |=> bank_reg[0].width == $past(boot_w))
    else $error("Bank-0 width not taken from straps");

  write_done_c: cover property (state_reg == ST_FINISH && dir_reg);
  read_done_c: cover property (state_reg == ST_FINISH && !dir_reg);
  granted_c: cover property ($fell(gnt_n_reg));
  extended_c: cover property (state_reg == ST_STROBE && cnt_reg > lim && !wait_s2);

  // ****************************************
  // Outputs
  // ****************************************
  assign S_AWREADY_O = awready_reg;
  assign S_WREADY_O = wready_reg;
  assign S_BVALID_O = bvalid_reg;
  assign S_BRESP_O = bresp_reg;
  assign S_ARREADY_O = arready_reg;
  assign S_RVALID_O = rvalid_reg;
  assign S_RDATA_O = rbus_reg;
  assign S_RRESP_O = rresp_reg;
  assign ADDR_O = pa_reg;
  assign BANK_SELECT_N_O = sel_reg;
  assign WRITE_STROBE_N_O = we_n_reg;
  assign READ_STROBE_N_O = oe_n_reg;
  assign DATA_O = dout_reg;
  assign DATA_OE_O = doe_reg;
  assign BUS_OE_O = boe_reg;
  assign BUS_HOLD_GRANT_N_O = gnt_n_reg;
endmodule // epi_top
`default_nettype wire

// *** verification/epi_mem_model.sv ***
// Static memory model on the far side of the external bus
`timescale 1ns/1ps
`default_nettype none
module epi_mem_model (
  input  wire logic        clk_i,     // Bus clock
  input  wire logic [26:0] addr_i,    // Location bus
  input  wire logic [31:0] wdata_i,   // Data from device
  input  wire logic        data_oe_i, // Device drives data
  input  wire logic        we_n_i,    // Write strobe
  input  wire logic        oe_n_i,    // Read strobe
  output var  logic [31:0] rdata_o    // Data to device
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;

  // Store while the write strobe is low; the last edge wins
  always @(posedge clk_i) begin
    if (!we_n_i && data_oe_i) begin
      mem[addr_i[5:2]] <= wdata_i;
    end
  end

  // Released bus toggles so a stale value never passes for data
  always_comb begin
    rdata_o = oe_n_i ? ~last_q : mem[addr_i[5:2]];
  end

  // Remember the last level for the release pattern
  always @(posedge clk_i) begin
    last_q <= rdata_o;
  end
endmodule // epi_mem_model
`default_nettype wire

// *** verification/external_bus_pin_interface_test.sv ***
// Register-level bench for the external bus pin interface
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_interface_test;
  import epi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic hold_n = 1'b1, ext_n = 1'b1;
  logic [1:0] boot = 2'b01;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, bus_oe, data_oe, we_n, oe_n, grant_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, din, dout, v;
  logic [26:0] paddr;
  logic [7:0] sel_n, sel_seen;
  logic [7:0] slo = 8'h00;
  int n_mismatch = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  epi_top epi_top_i (
    .SYS_CLK_I(clk), .RST_I(rst),
    .S_AWADDR_I(awaddr), .S_AWVALID_I(awv), .S_AWREADY_O(awrdy),
    .S_WDATA_I(wdata), .S_WSTRB_I(4'hF), .S_WVALID_I(wv), .S_WREADY_O(wrdy),
    .S_BRESP_O(bresp), .S_BVALID_O(bvalid), .S_BREADY_I(bready),
    .S_ARADDR_I(araddr), .S_ARVALID_I(arv), .S_ARREADY_O(arrdy),
    .S_RDATA_O(rdata), .S_RRESP_O(rresp), .S_RVALID_O(rvalid), .S_RREADY_I(rready),
    .BOOT_CONFIG_PINS_I(boot), .ADDR_O(paddr), .BUS_OE_O(bus_oe),
    .DATA_I(din), .DATA_O(dout), .DATA_OE_O(data_oe), .BANK_SELECT_N_O(sel_n),
    .WRITE_STROBE_N_O(we_n), .READ_STROBE_N_O(oe_n),
    .BUS_HOLD_REQUEST_N_I(hold_n), .BUS_HOLD_GRANT_N_O(grant_n),
    .CYCLE_EXTEND_N_I(ext_n)
  );

  epi_mem_model epi_mem_model_i (
    .clk_i(clk), .addr_i(paddr), .wdata_i(dout), .data_oe_i(data_oe),
    .we_n_i(we_n), .oe_n_i(oe_n), .rdata_o(din)
  );

  // Strobe-low length and the select seen meanwhile
  always @(posedge clk) begin
    if (!we_n || !oe_n) begin
      slo <= slo + 8'h01;
      sel_seen <= sel_n;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h, want %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      n++;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      n++;
    end while (!rvalid && n < 200);
    d = rdata;
    rready <= 1'b0;
    if (n >= 200) n_mismatch++;
  endtask

  // Poll for done, then clear done and error; v keeps the status
  task wait_done;
    int n;
    n = 0;
    v = 32'h0;
    while (!v[SB_DONE] && n < 100) begin
      rd(OFS_STAT, v);
      n++;
    end
    wr(OFS_STAT, 32'h0000_0006);
  endtask

  task go(input logic [31:0] a, input logic [31:0] c);
    wr(OFS_ADDR, a);
    slo = 8'h00;
    wr(OFS_CTRL, c);
    wait_done();
  endtask

  // Reset in mid-run with new straps; pins stay put well past the capture
  task reboot(input logic [1:0] code);
    @(posedge clk);
    boot <= code;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(sel_n, SEL_IDLE);
    chk({we_n, oe_n}, 2'b11);
    rd(OFS_BANK, v);
    chk(v, 32'h0000_0717);
    rd(OFS_STAT, v);
    chk(v, 32'h0000_0010);
    // Bank 2: 4 cycles, 32 bits; bank 3: 8 bits; bank 1: 1 MB only
    wr(OFS_BANK + 8'h08, 32'h0000_0724);
    wr(OFS_BANK + 8'h0C, 32'h0000_0704);
    wr(OFS_BANK + 8'h04, 32'h0000_0001);
    chk(bresp, RESP_OK);
    rd(OFS_BANK + 8'h08, v);
    chk(v, 32'h0000_0724);
    chk(rresp, RESP_OK);
    // A hole in the map answers with an error and reads as zero
    wr(OFS_STAT + 8'h04, 32'h0000_0001);
    chk(bresp, RESP_SLVERR);
    rd(OFS_STAT + 8'h04, v);
    chk(v, 32'h0000_0000);
    chk(rresp, RESP_SLVERR);
    wr(OFS_WDATA, 32'hA5C3_1E77);
    go(32'h1000_0010, 32'h0000_0003);
    chk(slo, 8'h05);
    chk(sel_seen, 8'hFB);
    chk({5'h00, paddr}, 32'h0000_0010);
    go(32'h1000_0010, 32'h0000_0001);
    rd(OFS_RDATA, v);
    chk(v, 32'hA5C3_1E77);
    go(32'h1800_0010, 32'h0000_0001);
    rd(OFS_RDATA, v);
    chk(v, 32'h0000_0077);
    chk(sel_seen, 8'hF7);
    // Bank 0 runs at the strap width, 16 bits, with reset cycle count
    go(32'h0000_0010, 32'h0000_0001);
    chk(slo, 8'h08);
    chk(sel_seen, 8'hFE);
    rd(OFS_RDATA, v);
    chk(v, 32'h0000_1E77);
    go(32'h0820_0000, 32'h0000_0001);
    chk(slo, 8'h00);
    chk(v[SB_ERR], 1'b1);
    // Hold the extend input well past the programmed strobe length
    ext_n <= 1'b0;
    fork
      begin
        repeat (30) @(posedge clk);
        ext_n <= 1'b1;
      end
    join_none
    go(32'h1000_0010, 32'h0000_0001);
    chk(slo > 8'd15, 1'b1);
    rd(OFS_RDATA, v);
    chk(v, 32'hA5C3_1E77);
    // Peer master asks for the bus and is granted once the pins float
    hold_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(grant_n, 1'b0);
    chk(bus_oe, 1'b0);
    // A start while the bus is handed over counts as busy and is dropped
    slo = 8'h00;
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (10) @(posedge clk);
    chk(slo, 8'h00);
    rd(OFS_STAT, v);
    chk(v, 32'h0000_0019);
    hold_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({grant_n, bus_oe}, 2'b11);
    go(32'h1000_0010, 32'h0000_0001);
    chk(slo, 8'h05);
    // Other strap codes: test mode, then nand boot
    reboot(BOOT_TEST);
    rd(OFS_BANK, v);
    chk(v, 32'h0000_0727);
    rd(OFS_STAT, v);
    chk(v, 32'h0000_0070);
    reboot(2'b00);
    chk(sel_n, SEL_IDLE);
    rd(OFS_BANK, v);
    chk(v, 32'h0000_0707);
    rd(OFS_STAT, v);
    chk(v, 32'h0000_0000);
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // external_bus_pin_interface_test
`default_nettype wire
